// ===== rtl/mqfs_top.sv
// flag-status logic of a 16-queue fifo: output valid, discrete and bus flags, width setup
// assumes queue status arrives on clk, pins are asynchronous, software on apb
//
// What this block does
// [R01] output valid flag goes high when the selected read queue is empty
// [R02] output valid flag can float so expanded devices share one wire
// [R03] output width strap is sampled at master reset and held stable after
// [R04] width straps give x9, x18 or x36 ports, one port always x36
// [R05] almost-empty flag low when selected read queue almost empty, on read clock
// [R06] read queue picked by read address with address enable on a clock edge
// [R07] almost-empty flag may also appear on one line of read flag bus
// [R08] almost-full flag low when selected write queue almost full, on write clock
// [R09] write queue picked by write address with address enable on a clock edge
// [R10] almost-full flag may also appear on one line of write flag bus
// [R11] read flag bus is 8 bits, one sector of 8 queues, 2 sectors
// [R12] read flag bus shows almost-empty or packet-ready per latched packet mode
// [R13] flag bus mode latched at master reset, buses run direct or polled
// [R14] both flag buses can float for expansion without contention
// [R15] direct mode: read address plus read strobe selects device and sector
// [R16] polled mode: read bus steps through sectors on each clock edge
// [R17] write flag bus is 8 bits carrying almost-full of one sector
// [R18] direct mode: write address, enable and strobe select write bus sector
// [R19] polled mode: write bus steps through sectors on each clock edge
// [R20] output valid trails read queue selection by two clock cycles
// [R21] address top 3 bits match device id, low 5 bits pick queue
// [R22] packet mode strap high selects packet mode when bus matching is off, low almost-empty mode
// [R23] direct mode bus holds last selected sector, refreshed every clock
// [R24] single-device polled mode alternates between the two sectors
`include "mqfs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mqfs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

module mqfs_top
    import mqfs_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`MQFS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // configuration straps
    input  wire logic                    master_reset_n,
    input  wire logic                    input_width_sel,
    input  wire logic                    output_width_sel,
    input  wire logic                    bus_match_sel,
    input  wire logic                    flag_bus_mode_sel,
    input  wire logic                    packet_mode_sel,
    input  wire logic [2:0]              device_identity_in,
    // read port selection pins
    input  wire logic [7:0]              read_queue_addr,
    input  wire logic                    read_addr_enable,
    input  wire logic                    read_flag_strobe,
    // write port selection pins
    input  wire logic [7:0]              write_queue_addr,
    input  wire logic                    write_addr_enable,
    input  wire logic                    write_flag_strobe,
    // queue core status
    input  wire mqfs_qstat_t             queue_status,
    // discrete flags, each with a low-active output enable
    output logic                         output_valid_flag_n,
    output logic                         output_valid_flag_oe_n,
    output logic                         almost_empty_flag_n,
    output logic                         almost_empty_flag_oe_n,
    output logic                         packet_ready_flag_n,
    output logic                         packet_ready_flag_oe_n,
    output logic                         almost_full_flag_n,
    output logic                         almost_full_flag_oe_n,
    // flag buses
    output logic [7:0]                   read_flag_bus,
    output logic                         read_flag_bus_oe_n,
    output logic [7:0]                   write_flag_bus,
    output logic                         write_flag_bus_oe_n,
    // port widths set at master reset
    output mqfs_width_t                  in_width,
    output mqfs_width_t                  out_width
);
    localparam int PINS = 29;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [PINS-1:0] pin_s;
    logic            mrs_s, iw_s, ow_s, bm_s, fm_s, pkt_s;
    logic [2:0]      id_s;
    logic [7:0]      raddr_s, waddr_s;
    logic            read_addr_enable_s, read_flag_strobe_s, write_addr_enable_s, write_flag_strobe_s;
    logic [3:0]      raddr_q, waddr_q;
    logic            rd_dev_hit, wr_dev_hit;
    mqfs_cfg_t       cfg_reg, cfg_next;

    mqfs_sync #(.WIDTH(PINS)) u_pin_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({master_reset_n, input_width_sel, output_width_sel, bus_match_sel,
                flag_bus_mode_sel, packet_mode_sel, device_identity_in,
                read_queue_addr, read_addr_enable, read_flag_strobe,
                write_queue_addr, write_addr_enable, write_flag_strobe}),
        .q    (pin_s)
    );

    assign {mrs_s, iw_s, ow_s, bm_s, fm_s, pkt_s, id_s, raddr_s, read_addr_enable_s, read_flag_strobe_s,
            waddr_s, write_addr_enable_s, write_flag_strobe_s} = pin_s;
    assign raddr_q    = raddr_s[3:0];
    assign waddr_q    = waddr_s[3:0];
    // queue numbers 16..31 exist in the address space but not in this device
    assign rd_dev_hit = (raddr_s[7:5] == cfg_reg.dev_id) && !raddr_s[4]; // R21
    assign wr_dev_hit = (waddr_s[7:5] == cfg_reg.dev_id) && !waddr_s[4]; // R21

    // ---- configuration caught while master reset is held

    always_comb begin
        cfg_next        = '0;
        cfg_next.in_w   = MQFS_X36;
        cfg_next.out_w  = MQFS_X36;
        if (bm_s) begin // R04
            case ({iw_s, ow_s})
                2'b00:   cfg_next.in_w  = MQFS_X18;
                2'b01:   cfg_next.in_w  = MQFS_X9;
                2'b10:   cfg_next.out_w = MQFS_X18;
                default: cfg_next.out_w = MQFS_X9;
            endcase
        end
        // packet mode needs x36 on both ports, else fall back to almost-empty
        cfg_next.pkt    = pkt_s && !bm_s; // R22
        cfg_next.polled = fm_s;
        cfg_next.dev_id = id_s;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= '0;
        end else if (!mrs_s) begin
            cfg_reg <= cfg_next; // R03 R13
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_width  <= MQFS_X36;
            out_width <= MQFS_X36;
        end else begin
            in_width  <= cfg_reg.in_w;
            out_width <= cfg_reg.out_w;
        end
    end

    // ---- software control
    logic       dup_rd_reg, dup_wr_reg;
    logic [2:0] rd_line_reg, wr_line_reg;

    // ---- read queue selection and discrete read flags
    logic [3:0] rd_q_reg;
    logic       rd_hit_reg;
    logic       rd_empty_sel, rd_ae_sel, rd_pr_sel;
    logic       ov_p1_reg, ov_oe_p1_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_q_reg   <= '0;
            rd_hit_reg <= 1'b0;
        end else if (!mrs_s) begin
            rd_q_reg   <= '0;
            rd_hit_reg <= 1'b0;
        end else if (read_addr_enable_s) begin
            rd_q_reg   <= raddr_q; // R06
            rd_hit_reg <= rd_dev_hit;
        end
    end

    assign rd_empty_sel = queue_status.empty[rd_q_reg];
    assign rd_ae_sel    = queue_status.ae_n[rd_q_reg];
    assign rd_pr_sel    = cfg_reg.pkt ? queue_status.pr_n[rd_q_reg] : 1'b1;

    // two stages so the flag lines up with the read data path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ov_p1_reg              <= 1'b1;
            ov_oe_p1_reg           <= 1'b1;
            output_valid_flag_n    <= 1'b1;
            output_valid_flag_oe_n <= 1'b1;
        end else begin
            ov_p1_reg              <= rd_empty_sel; // R01 R20
            ov_oe_p1_reg           <= !rd_hit_reg;
            output_valid_flag_n    <= ov_p1_reg;
            output_valid_flag_oe_n <= ov_oe_p1_reg; // R02
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            almost_empty_flag_n    <= 1'b1;
            almost_empty_flag_oe_n <= 1'b1;
            packet_ready_flag_n    <= 1'b1;
            packet_ready_flag_oe_n <= 1'b1;
        end else begin
            almost_empty_flag_n    <= rd_ae_sel; // R05
            almost_empty_flag_oe_n <= !rd_hit_reg;
            packet_ready_flag_n    <= rd_pr_sel;
            packet_ready_flag_oe_n <= !(rd_hit_reg && cfg_reg.pkt);
        end
    end

    // ---- write queue selection and discrete write flag
    logic [3:0] wr_q_reg;
    logic       wr_hit_reg;
    logic       wr_af_sel;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q_reg   <= '0;
            wr_hit_reg <= 1'b0;
        end else if (!mrs_s) begin
            wr_q_reg   <= '0;
            wr_hit_reg <= 1'b0;
        end else if (write_addr_enable_s) begin
            wr_q_reg   <= waddr_q; // R09
            wr_hit_reg <= wr_dev_hit;
        end
    end

    assign wr_af_sel = queue_status.af_n[wr_q_reg];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            almost_full_flag_n    <= 1'b1;
            almost_full_flag_oe_n <= 1'b1;
        end else begin
            almost_full_flag_n    <= wr_af_sel; // R08
            almost_full_flag_oe_n <= !wr_hit_reg;
        end
    end

    // ---- read flag bus
    logic       rsec_reg, rbus_en_reg;
    logic [7:0] rd_slice_raw, rd_slice;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsec_reg    <= 1'b0;
            rbus_en_reg <= 1'b0;
        end else if (!mrs_s) begin
            rsec_reg    <= 1'b0;
            rbus_en_reg <= 1'b0;
        end else if (cfg_reg.polled) begin
            rsec_reg    <= !rsec_reg; // R16 R24
            rbus_en_reg <= 1'b1;
        end else if (read_flag_strobe_s) begin
            rsec_reg    <= raddr_s[3]; // R15 R23
            rbus_en_reg <= rd_dev_hit;
        end
    end

    always_comb begin
        if (cfg_reg.pkt) begin
            rd_slice_raw = rsec_reg ? queue_status.pr_n[15:8] : queue_status.pr_n[7:0]; // R12
        end else begin
            rd_slice_raw = rsec_reg ? queue_status.ae_n[15:8] : queue_status.ae_n[7:0]; // R11
        end
        rd_slice = rd_slice_raw;
        if (dup_rd_reg && rd_hit_reg) begin
            rd_slice[rd_line_reg] = cfg_reg.pkt ? rd_pr_sel : rd_ae_sel; // R07
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            read_flag_bus      <= 8'hff;
            read_flag_bus_oe_n <= 1'b1;
        end else begin
            read_flag_bus      <= rd_slice; // R23
            read_flag_bus_oe_n <= !rbus_en_reg; // R14
        end
    end

    // ---- write flag bus
    logic       wsec_reg, wbus_en_reg;
    logic [7:0] wr_slice_raw, wr_slice;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wsec_reg    <= 1'b0;
            wbus_en_reg <= 1'b0;
        end else if (!mrs_s) begin
            wsec_reg    <= 1'b0;
            wbus_en_reg <= 1'b0;
        end else if (cfg_reg.polled) begin
            wsec_reg    <= !wsec_reg; // R19 R24
            wbus_en_reg <= 1'b1;
        end else if (write_flag_strobe_s && write_addr_enable_s) begin
            wsec_reg    <= waddr_s[3]; // R18
            wbus_en_reg <= wr_dev_hit;
        end
    end

    always_comb begin
        wr_slice_raw = wsec_reg ? queue_status.af_n[15:8] : queue_status.af_n[7:0]; // R17
        wr_slice     = wr_slice_raw;
        if (dup_wr_reg && wr_hit_reg) begin
            wr_slice[wr_line_reg] = wr_af_sel; // R10
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_flag_bus      <= 8'hff;
            write_flag_bus_oe_n <= 1'b1;
        end else begin
            write_flag_bus      <= wr_slice;
            write_flag_bus_oe_n <= !wbus_en_reg; // R14
        end
    end

    // ---- apb slave, no wait state on any transfer, pready high in the first access cycle
    logic [31:0] rd_mux;
    logic        addr_ok, wr_ok, do_write;

    always_comb begin
        rd_mux  = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            `MQFS_CTRL_OFF: begin
                rd_mux[`MQFS_CTRL_DUP_RD]       = dup_rd_reg;
                rd_mux[`MQFS_CTRL_DUP_WR]       = dup_wr_reg;
                rd_mux[`MQFS_CTRL_RD_LINE +: 3] = rd_line_reg;
                rd_mux[`MQFS_CTRL_WR_LINE +: 3] = wr_line_reg;
            end
            `MQFS_CFG_OFF: begin
                rd_mux[`MQFS_CFG_IN_W +: 2]   = cfg_reg.in_w;
                rd_mux[`MQFS_CFG_OUT_W +: 2]  = cfg_reg.out_w;
                rd_mux[`MQFS_CFG_PKT]         = cfg_reg.pkt;
                rd_mux[`MQFS_CFG_POLLED]      = cfg_reg.polled;
                rd_mux[`MQFS_CFG_DEV_ID +: 3] = cfg_reg.dev_id;
                rd_mux[`MQFS_CFG_MRS]         = !mrs_s;
            end
            `MQFS_STAT_OFF: begin
                rd_mux[`MQFS_STAT_RD_Q +: 4] = rd_q_reg;
                rd_mux[`MQFS_STAT_RD_HIT]    = rd_hit_reg;
                rd_mux[`MQFS_STAT_WR_Q +: 4] = wr_q_reg;
                rd_mux[`MQFS_STAT_WR_HIT]    = wr_hit_reg;
                rd_mux[`MQFS_STAT_RD_SEC]    = rsec_reg;
                rd_mux[`MQFS_STAT_WR_SEC]    = wsec_reg;
                rd_mux[`MQFS_STAT_OV]        = output_valid_flag_n;
                rd_mux[`MQFS_STAT_AE]        = almost_empty_flag_n;
                rd_mux[`MQFS_STAT_AF]        = almost_full_flag_n;
                rd_mux[`MQFS_STAT_PR]        = packet_ready_flag_n;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    assign wr_ok    = (paddr == `MQFS_CTRL_OFF);
    assign do_write = psel && penable && pready && pwrite && wr_ok;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            // status and config are read-only, so writes there are refused
            pslverr <= !addr_ok || (pwrite && !wr_ok);
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dup_rd_reg  <= 1'(`MQFS_CTRL_RST >> `MQFS_CTRL_DUP_RD);
            dup_wr_reg  <= 1'b0;
            rd_line_reg <= 3'h0;
            wr_line_reg <= 3'h0;
        end else if (do_write) begin
            dup_rd_reg  <= pwdata[`MQFS_CTRL_DUP_RD];
            dup_wr_reg  <= pwdata[`MQFS_CTRL_DUP_WR];
            rd_line_reg <= pwdata[`MQFS_CTRL_RD_LINE +: 3];
            wr_line_reg <= pwdata[`MQFS_CTRL_WR_LINE +: 3];
        end
    end

    // ---- checks
    logic [1:0] age_reg;
    logic       warm;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    assign warm = (age_reg == 2'h3);

    property p_ov_delay;
        warm |-> output_valid_flag_n == $past(rd_empty_sel, 2);
    endproperty
    a_ov_delay: assert property (p_ov_delay) else $error("output valid not two cycles behind"); // R20

    property p_ov_float;
        warm && !rd_hit_reg |-> ##2 output_valid_flag_oe_n;
    endproperty
    a_ov_float: assert property (p_ov_float) else $error("output valid driven while unselected"); // R02

    property p_ae_flag;
        warm |-> almost_empty_flag_n == $past(rd_ae_sel);
    endproperty
    a_ae_flag: assert property (p_ae_flag) else $error("almost-empty flag wrong"); // R05

    property p_af_flag;
        warm |-> almost_full_flag_n == $past(wr_af_sel);
    endproperty
    a_af_flag: assert property (p_af_flag) else $error("almost-full flag wrong"); // R08

    property p_rd_select;
        mrs_s && read_addr_enable_s && rd_dev_hit |=> rd_hit_reg && rd_q_reg == $past(raddr_q);
    endproperty
    a_rd_select: assert property (p_rd_select) else $error("read queue not selected"); // R06

    property p_rd_poll;
        mrs_s && cfg_reg.polled |=> rsec_reg != $past(rsec_reg);
    endproperty
    a_rd_poll: assert property (p_rd_poll) else $error("read bus sector did not step"); // R16

    property p_rd_hold;
        mrs_s && !cfg_reg.polled && !read_flag_strobe_s |=> $stable(rsec_reg);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read bus sector moved unstrobed"); // R23

    property p_wr_bus;
        warm && !dup_wr_reg |=> write_flag_bus == $past(wr_slice_raw);
    endproperty
    a_wr_bus: assert property (p_wr_bus) else $error("write flag bus content wrong"); // R17

    property p_cfg_hold;
        mrs_s |=> $stable(cfg_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside master reset"); // R13

    property p_width;
        warm |-> in_width == MQFS_X36 || out_width == MQFS_X36;
    endproperty
    a_width: assert property (p_width) else $error("neither port is x36"); // R04

endmodule

`default_nettype wire

// ===== rtl/mqfs_defs.svh
// offsets, field positions, reset values and timing counts of the flag-status block
// assumes a 32-bit apb slave with byte addresses in paddr
`ifndef MQFS_DEFS_SVH
`define MQFS_DEFS_SVH

`define MQFS_ADDR_W        12
`define MQFS_CTRL_OFF      12'h000
`define MQFS_CFG_OFF       12'h004
`define MQFS_STAT_OFF      12'h008

`define MQFS_CTRL_DUP_RD   0
`define MQFS_CTRL_DUP_WR   1
`define MQFS_CTRL_RD_LINE  4
`define MQFS_CTRL_WR_LINE  8
`define MQFS_CTRL_RST      32'h0000_0000

`define MQFS_CFG_IN_W      0
`define MQFS_CFG_OUT_W     2
`define MQFS_CFG_PKT       4
`define MQFS_CFG_POLLED    5
`define MQFS_CFG_DEV_ID    8
`define MQFS_CFG_MRS       12

`define MQFS_STAT_RD_Q     0
`define MQFS_STAT_RD_HIT   4
`define MQFS_STAT_WR_Q     8
`define MQFS_STAT_WR_HIT   12
`define MQFS_STAT_RD_SEC   16
`define MQFS_STAT_WR_SEC   17
`define MQFS_STAT_OV       20
`define MQFS_STAT_AE       21
`define MQFS_STAT_AF       22
`define MQFS_STAT_PR       23

`define MQFS_SYNC_STAGES   2
`define MQFS_OV_DELAY      2

`endif

// ===== rtl/mqfs_pkg.sv
// types shared by the flag-status block
// assumes 16 queues in two sectors of 8
package mqfs_pkg;

    typedef enum logic [1:0] {
        MQFS_X9,
        MQFS_X18,
        MQFS_X36
    } mqfs_width_t;

    // per-queue status from the queue core, same clock
    typedef struct packed {
        logic [15:0] empty;
        logic [15:0] ae_n;
        logic [15:0] af_n;
        logic [15:0] pr_n;
    } mqfs_qstat_t;

    // configuration caught during master reset
    typedef struct packed {
        mqfs_width_t in_w;
        mqfs_width_t out_w;
        logic        pkt;
        logic        polled;
        logic [2:0]  dev_id;
    } mqfs_cfg_t;

endpackage

// ===== verif/mqfs_user_model.sv
// user logic on the read and write ports: picks queues, strobes sectors, feeds queue status
// assumes it shares clk with the flag block and changes pins just after rising edges
`timescale 1ns/1ps
`default_nettype none
module mqfs_user_model
    import mqfs_pkg::*;
(
    // clock
    input  wire logic  clk,
    // read port pins
    output logic [7:0] read_queue_addr,
    output logic       read_addr_enable,
    output logic       read_flag_strobe,
    // write port pins
    output logic [7:0] write_queue_addr,
    output logic       write_addr_enable,
    output logic       write_flag_strobe,
    // queue core status
    output mqfs_qstat_t queue_status
);
    initial begin
        {read_queue_addr, read_addr_enable, read_flag_strobe} = 10'h3fc;
        {write_queue_addr, write_addr_enable, write_flag_strobe} = 10'h3fc;
        queue_status = {16'h0020, 16'h5a3c, 16'hc3a5, 16'h0ff0};
    end
    // one clock of request; released address lines flip so a stale address is never reused
    task automatic sel(input logic rd, input logic [7:0] a, input logic en, input logic stb);
        if (rd) begin
            read_queue_addr  <= a;
            read_addr_enable <= en;
            read_flag_strobe <= stb;
        end else begin
            write_queue_addr  <= a;
            write_addr_enable <= en;
            write_flag_strobe <= stb;
        end
        @(posedge clk);
        {read_addr_enable, read_flag_strobe, write_addr_enable, write_flag_strobe} <= 4'h0;
        read_queue_addr  <= ~read_queue_addr;
        write_queue_addr <= ~write_queue_addr;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_multi_queue_flag_status.sv
// self-checking bench of the flag-status block: apb, straps, selection and flag buses
// assumes the user model drives port pins and queue status; pins are synced two flops inside
`timescale 1ns/1ps
`default_nettype none
module tb_multi_queue_flag_status
    import mqfs_pkg::*;
;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    logic master_reset_n = 1, input_width_sel = 0, output_width_sel = 0, bus_match_sel = 0;
    logic flag_bus_mode_sel = 0, packet_mode_sel = 0;
    logic [2:0] device_identity_in = 3'h0;
    logic [7:0] read_queue_addr, write_queue_addr, read_flag_bus, write_flag_bus, a, b;
    logic read_addr_enable, read_flag_strobe, write_addr_enable, write_flag_strobe;
    mqfs_qstat_t queue_status;
    logic output_valid_flag_n, output_valid_flag_oe_n, almost_empty_flag_n, almost_empty_flag_oe_n;
    logic packet_ready_flag_n, packet_ready_flag_oe_n, almost_full_flag_n, almost_full_flag_oe_n;
    logic read_flag_bus_oe_n, write_flag_bus_oe_n;
    mqfs_width_t in_width, out_width;
    int bad_count = 0, total_checks = 0, cyc = 0;

    mqfs_top        u_mqfs_top (.*);
    mqfs_user_model u_mqfs_user_model (.*);

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, er, input logic ee);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        if (!wr)
            chk(prdata, er);
        chk(pslverr, ee);
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    // straps only move while master reset is held, never in operation
    task automatic mreset(input logic fm, pk, bm, iw, ow);
        {flag_bus_mode_sel, packet_mode_sel, bus_match_sel} <= {fm, pk, bm};
        {input_width_sel, output_width_sel, master_reset_n} <= {iw, ow, 1'b0};
        repeat (6) @(posedge clk);
        master_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_regs();
        apb(0, 12'h000, 0, 32'h0, 0);
        apb(1, 12'h004, 32'h1, 0, 1);
        apb(0, 12'h00c, 0, 32'h0, 1);
        apb(0, 12'h004, 0, 32'h0000_000a, 0);
        chk(in_width, MQFS_X36);
        chk(out_width, MQFS_X36);
    endtask
    task automatic t_select();
        u_mqfs_user_model.sel(1, 8'h05, 1, 0);
        chk({output_valid_flag_n, output_valid_flag_oe_n}, 2'b10);
        chk({almost_empty_flag_n, almost_empty_flag_oe_n}, 2'b10);
        u_mqfs_user_model.sel(1, 8'h04, 1, 0);
        chk({output_valid_flag_n, almost_empty_flag_n}, 2'b01);
        u_mqfs_user_model.sel(0, 8'h0a, 1, 0);
        chk({almost_full_flag_n, almost_full_flag_oe_n}, 2'b00);
        u_mqfs_user_model.sel(1, 8'h25, 1, 0);
        chk({output_valid_flag_oe_n, almost_empty_flag_oe_n}, 2'b11);
    endtask
    task automatic t_direct();
        u_mqfs_user_model.sel(1, 8'h08, 0, 1);
        chk({read_flag_bus_oe_n, read_flag_bus}, {1'b0, 8'h5a});
        repeat (5) @(posedge clk);
        chk(read_flag_bus, 8'h5a);
        u_mqfs_user_model.sel(0, 8'h00, 1, 1);
        chk({write_flag_bus_oe_n, write_flag_bus}, {1'b0, 8'ha5});
        u_mqfs_user_model.sel(1, 8'h20, 0, 1);
        chk(read_flag_bus_oe_n, 1'b1);
        apb(1, 12'h000, 32'h0000_0523, 0, 0);
        apb(0, 12'h000, 0, 32'h0000_0523, 0);
        u_mqfs_user_model.sel(1, 8'h0c, 1, 1);
        chk(read_flag_bus, 8'h5e);
        u_mqfs_user_model.sel(0, 8'h01, 1, 1);
        chk(write_flag_bus, 8'h85);
        apb(0, 12'h008, 0, 32'h00a1_111c, 0);
    endtask
    task automatic t_polled();
        mreset(1, 0, 0, 0, 0);
        @(posedge clk);
        a = read_flag_bus;
        @(posedge clk);
        chk({a, read_flag_bus} == 16'h3c5a || {a, read_flag_bus} == 16'h5a3c, 1);
        a = write_flag_bus;
        @(posedge clk);
        b = write_flag_bus;
        chk({a, b} == 16'ha5c3 || {a, b} == 16'hc3a5, 1);
    endtask
    task automatic t_packet();
        mreset(0, 1, 0, 0, 0);
        u_mqfs_user_model.sel(1, 8'h00, 1, 1);
        chk(read_flag_bus, 8'hf0);
        chk({packet_ready_flag_n, packet_ready_flag_oe_n}, 2'b00);
        mreset(0, 0, 1, 0, 1);
        chk({in_width, out_width}, {MQFS_X9, MQFS_X36});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        mreset(0, 0, 0, 0, 0);
        t_regs();
        t_select();
        t_direct();
        t_polled();
        t_packet();
        complete_run();
    end
endmodule
`default_nettype wire
